// ==== dv/scsi_bus_peer.sv ====
`default_nettype none
module scsi_bus_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic data_strobe,
  input wire logic slow,
  output logic ack_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int pending;
  int wait_cnt;
  // one ack pulse per strobe, after a short or a long delay
  always @(posedge clk) begin
    if (!rst_n) begin
      pending = 0;
      wait_cnt = 0;
      ack_pin <= 1'b0;
    end else begin
      if (data_strobe === 1'b1) pending = pending + 1;
      if (ack_pin) ack_pin <= 1'b0;
      else if (pending > 0 && wait_cnt >= (slow ? 12 : 2)) begin
        ack_pin <= 1'b1;
        pending = pending - 1;
        wait_cnt = 0;
      end else wait_cnt = wait_cnt + 1;
    end
  end
endmodule // scsi_bus_peer
`default_nettype wire

// ==== dv/tb_scsi_id_sync_xfer_config.sv ====
`default_nettype none
module tb_scsi_id_sync_xfer_config
  import scsi_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, slow;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic role_target_in, role_target, script_dest_we, table_load, sel_seen_pin, resel_seen_pin;
  logic [2:0] script_dest_id;
  logic [7:0] table_xfer, bus_ids_pin, arb_id_drive;
  logic sel_respond, resel_respond, arb_won, send_req, sending, ack_pin, data_strobe, sync_mode;
  logic [4:0] outstanding;
  phase_t phase;
  int bad_count, check_count, cycles;
  scsi_id_sync_xfer_config DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .role_target_in(role_target_in), .role_target(role_target), .script_dest_we(script_dest_we),
    .script_dest_id(script_dest_id), .table_load(table_load), .table_xfer(table_xfer),
    .sel_seen_pin(sel_seen_pin), .resel_seen_pin(resel_seen_pin), .bus_ids_pin(bus_ids_pin),
    .sel_respond(sel_respond), .resel_respond(resel_respond), .arb_id_drive(arb_id_drive), .arb_won(arb_won),
    .scsi_clk_tick(1'b1), .send_req(send_req), .sending(sending), .phase(phase), .ack_pin(ack_pin),
    .data_strobe(data_strobe), .sync_mode(sync_mode), .outstanding(outstanding));
  scsi_bus_peer peer (.clk(clk), .rst_n(rst_n), .data_strobe(data_strobe), .slow(slow), .ack_pin(ack_pin));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {22'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk("prdata", {24'h0, exp}, rd);
  endtask
  task automatic test_regs();
    logic [9:0] ad[4];
    logic [7:0] mk[4];
    ad = '{own_id_addr, xfer_addr, dest_addr, clkdiv_addr};
    mk = '{own_id_mask, xfer_mask, dest_mask, clkdiv_mask};
    for (int i = 0; i < 4; i++) rchk(ad[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ad[i], 32'hFFFFFFFF);
      rchk(ad[i], mk[i]);
    end
    apb(1'b1, 10'h0F0, 32'h000000FF);
    chk("pslverr", 32'h1, {31'h0, err});
    rchk(10'h0F0, 8'h00);
    $display("done: registers");
  endtask
  task automatic test_sel(input logic r, input logic e, input logic [2:0] id);
    role_target_in <= ~r;
    apb(1'b1, own_id_addr, {24'h0, 1'b0, e & r, e & ~r, 2'b00, id});
    sel_seen_pin <= ~r;
    resel_seen_pin <= r;
    bus_ids_pin <= 8'h24;
    repeat (6) @(posedge clk);
    chk("sel_respond", {31'h0, e & ~r & (id == 3'h5)}, {31'h0, sel_respond});
    chk("resel_respond", {31'h0, e & r & (id == 3'h5)}, {31'h0, resel_respond});
    chk("role_target", {31'h0, ~r}, {31'h0, role_target});
    sel_seen_pin <= 1'b0;
    resel_seen_pin <= 1'b0;
    bus_ids_pin <= 8'h00;
    repeat (6) @(posedge clk);
  endtask
  task automatic test_arb_load();
    apb(1'b1, own_id_addr, 32'h5);
    bus_ids_pin <= 8'h21;
    repeat (6) @(posedge clk);
    chk("arb_id_drive", 32'h20, {24'h0, arb_id_drive});
    chk("arb_won", 32'h1, {31'h0, arb_won});
    bus_ids_pin <= 8'hA0;
    repeat (6) @(posedge clk);
    chk("arb_won", 32'h0, {31'h0, arb_won});
    apb(1'b1, own_id_addr, 32'h7);
    repeat (6) @(posedge clk);
    chk("arb_won", 32'h1, {31'h0, arb_won});
    chk("arb_id_drive", 32'h80, {24'h0, arb_id_drive});
    bus_ids_pin <= 8'h00;
    script_dest_we <= 1'b1;
    script_dest_id <= 3'h6;
    table_load <= 1'b1;
    table_xfer <= 8'hB7;
    @(posedge clk);
    script_dest_we <= 1'b0;
    table_load <= 1'b0;
    rchk(dest_addr, 8'h06);
    rchk(xfer_addr, 8'hB7 & xfer_mask);
    $display("done: arbitration and loads");
  endtask
  task automatic gap(input int exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (data_strobe !== 1'b1 && n < 60);
    end
    chk("strobe gap", exp, n);
  endtask
  task automatic sync_chk(input logic exp);
    @(posedge clk);
    chk("sync_mode", {31'h0, exp}, {31'h0, sync_mode});
  endtask
  task automatic test_sync();
    int mx;
    apb(1'b1, clkdiv_addr, 32'h1);
    apb(1'b1, xfer_addr, 32'h22);
    phase <= phase_data_out;
    sending <= 1'b1;
    send_req <= 1'b1;
    gap(5);
    apb(1'b1, clkdiv_addr, 32'h81);
    gap(6);
    apb(1'b1, clkdiv_addr, 32'h3);
    gap(10);
    apb(1'b1, clkdiv_addr, 32'h1);
    phase <= phase_other;
    sync_chk(1'b0);
    phase <= phase_data_in;
    sync_chk(1'b1);
    phase <= phase_data_out;
    slow <= 1'b1;
    mx = 0;
    repeat (80) begin
      @(posedge clk);
      if (outstanding > mx) mx = outstanding;
    end
    chk("max outstanding", 32'h2, mx);
    apb(1'b1, xfer_addr, 32'h09);
    sync_chk(1'b0);
    apb(1'b1, xfer_addr, 32'h00);
    sync_chk(1'b0);
    send_req <= 1'b0;
    sending <= 1'b0;
    $display("done: synchronous transfer");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, slow, role_target_in, script_dest_we, table_load} = '0;
    {sel_seen_pin, resel_seen_pin, send_req, sending} = '0;
    {paddr, pwdata, script_dest_id, table_xfer, bus_ids_pin} = '0;
    phase = phase_other;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    test_regs();
    for (int i = 0; i < 6; i++) test_sel(i[0], i < 4 ? i[1] : 1'b1, i < 4 ? 3'h5 : 3'h3);
    $display("done: selection");
    test_arb_load();
    test_sync();
    end_sim();
  end
endmodule // tb_scsi_id_sync_xfer_config
`default_nettype wire

// ==== src/scsi_cfg_pkg.sv ====
`default_nettype none
package scsi_cfg_pkg;
  // register byte offsets (word aligned: printed offsets are indices)
  localparam logic [7:0] own_id_index = 8'h04;
  localparam logic [7:0] xfer_index = 8'h05;
  localparam logic [7:0] dest_index = 8'h06;
  localparam logic [7:0] clkdiv_index = 8'h07;
  localparam logic [7:0] status_index = 8'h08;
  localparam logic [9:0] own_id_addr = {own_id_index, 2'b00};
  localparam logic [9:0] xfer_addr = {xfer_index, 2'b00};
  localparam logic [9:0] dest_addr = {dest_index, 2'b00};
  localparam logic [9:0] clkdiv_addr = {clkdiv_index, 2'b00};
  localparam logic [9:0] status_addr = {status_index, 2'b00};
  // field positions
  localparam int resel_en_bit = 6;
  localparam int sel_en_bit = 5;
  localparam int period_lsb = 5;
  localparam int extra_setup_bit = 7;
  // reset values and writable masks
  localparam logic [7:0] own_id_reset = 8'h00;
  localparam logic [7:0] xfer_reset = 8'h00;
  localparam logic [7:0] dest_reset = 8'h00;
  localparam logic [7:0] clkdiv_reset = 8'h00;
  localparam logic [7:0] own_id_mask = 8'h67;
  localparam logic [7:0] xfer_mask = 8'hEF;
  localparam logic [7:0] dest_mask = 8'h07;
  localparam logic [7:0] clkdiv_mask = 8'h87;
  // timing
  localparam logic [3:0] period_base = 4'h4;
  localparam logic [4:0] max_offset_limit = 5'h08;
  // divider codes, counted in half scsi clocks
  localparam logic [2:0] div_code_3a = 3'h0;
  localparam logic [2:0] div_code_1 = 3'h1;
  localparam logic [2:0] div_code_15 = 3'h2;
  localparam logic [2:0] div_code_2 = 3'h3;
  localparam logic [2:0] div_code_3b = 3'h4;

  typedef struct packed {
    logic resel_en;
    logic sel_en;
    logic [2:0] own_id;
  } id_cfg_t;

  typedef struct packed {
    logic [2:0] period_code;
    logic [3:0] max_offset;
  } xfer_cfg_t;

  typedef enum logic [1:0] {
    phase_data_out,
    phase_data_in,
    phase_other
  } phase_t;
endpackage
`default_nettype wire

// ==== src/scsi_id_sync_xfer_config.sv ====
// Contract
// - respond to reselection at own ID only while reselection enable is set
// - reselection never changes the configured role
// - respond to selection at own ID only while selection enable is set
// - selection never changes the configured role
// - own ID is 3-bit binary, driven in arbitration, matched in selection
// - arbitration priority descends from ID 7 to ID 0
// - table-indirect load writes all eight transfer control bits (the code stores seven: xfer_mask clears bit 4)
// - send period is code plus four core clocks
// - one extra setup clock only when enabled and sending
// - offset 0 asynchronous, 1..8 synchronous, larger codes reserved
// - offset governs only data in and data out phases
// - destination ID write selects target or initiator for later phases (the code only stores the ID; role follows role_target_in)
// - script processor writes destination ID from select instruction
// - core clock is scsi clock divided by 3, 1, 1.5, 2 or 3
`default_nettype none
module scsi_id_sync_xfer_config
  import scsi_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic role_target_in,
  output logic role_target,
  input wire logic script_dest_we,
  input wire logic [2:0] script_dest_id,
  input wire logic table_load,
  input wire logic [7:0] table_xfer,
  input wire logic sel_seen_pin,
  input wire logic resel_seen_pin,
  input wire logic [7:0] bus_ids_pin,
  output logic sel_respond,
  output logic resel_respond,
  output logic [7:0] arb_id_drive,
  output logic arb_won,
  input wire logic scsi_clk_tick,
  input wire logic send_req,
  input wire logic sending,
  input wire phase_t phase,
  input wire logic ack_pin,
  output logic data_strobe,
  output logic sync_mode,
  output logic [4:0] outstanding
);
  logic [7:0] own_id_reg;
  logic [7:0] xfer_reg;
  logic [7:0] dest_reg;
  logic [7:0] clkdiv_reg;
  logic [1:0] sel_sync;
  logic [1:0] resel_sync;
  logic [7:0] ids_s1;
  logic [7:0] ids_s2;
  logic [1:0] ack_sync;
  logic ack_prev;
  logic core_tick;
  logic [3:0] gap_cnt;
  logic [3:0] computed_period;
  logic offset_ok;
  id_cfg_t id_cfg;
  xfer_cfg_t xfer_cfg;
  logic wr;
  logic [7:0] mapped;

  function automatic logic [7:0] id_onehot(input logic [2:0] code);
    id_onehot = 8'h01 << code;
  endfunction

  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:10] == 22'h0) && (a[9:0] inside {own_id_addr, xfer_addr, dest_addr, clkdiv_addr, status_addr});
  endfunction

  assign id_cfg = '{resel_en: own_id_reg[resel_en_bit], sel_en: own_id_reg[sel_en_bit], own_id: own_id_reg[2:0]};
  assign xfer_cfg = '{period_code: xfer_reg[7:period_lsb], max_offset: xfer_reg[3:0]};
  assign wr = psel && penable && pwrite && clk_en;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_hit(paddr);
  // role is software's alone; selection events never touch it
  assign role_target = role_target_in;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      own_id_reg <= own_id_reset;
      clkdiv_reg <= clkdiv_reset;
    end else if (wr) begin
      if (paddr[9:0] == own_id_addr) own_id_reg <= pwdata[7:0] & own_id_mask;
      if (paddr[9:0] == clkdiv_addr) clkdiv_reg <= pwdata[7:0] & clkdiv_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      xfer_reg <= xfer_reset;
    end else if (clk_en) begin
      if (table_load) xfer_reg <= table_xfer & xfer_mask;
      else if (wr && paddr[9:0] == xfer_addr) xfer_reg <= pwdata[7:0] & xfer_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dest_reg <= dest_reset;
    end else if (clk_en) begin
      if (script_dest_we) dest_reg <= {5'h00, script_dest_id};
      else if (wr && paddr[9:0] == dest_addr) dest_reg <= pwdata[7:0] & dest_mask;
    end
  end

  always_comb begin
    unique case (paddr[9:0])
      own_id_addr: mapped = own_id_reg;
      xfer_addr: mapped = xfer_reg;
      dest_addr: mapped = dest_reg;
      clkdiv_addr: mapped = clkdiv_reg;
      status_addr: mapped = {sync_mode, arb_won, resel_respond, sel_respond, outstanding[3:0]};
      default: mapped = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (clk_en && psel && !penable && !pwrite) prdata <= {24'h000000, mapped};
  end

  // pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_sync <= 2'b00;
      resel_sync <= 2'b00;
      ids_s1 <= 8'h00;
      ids_s2 <= 8'h00;
      ack_sync <= 2'b00;
    end else if (clk_en) begin
      sel_sync <= {sel_sync[0], sel_seen_pin};
      resel_sync <= {resel_sync[0], resel_seen_pin};
      ids_s1 <= bus_ids_pin;
      ids_s2 <= ids_s1;
      ack_sync <= {ack_sync[0], ack_pin};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_respond <= 1'b0;
      resel_respond <= 1'b0;
      arb_id_drive <= 8'h00;
      arb_won <= 1'b0;
    end else if (clk_en) begin
      sel_respond <= sel_sync[1] && id_cfg.sel_en && ids_s2[id_cfg.own_id];
      resel_respond <= resel_sync[1] && id_cfg.resel_en && ids_s2[id_cfg.own_id];
      arb_id_drive <= id_onehot(id_cfg.own_id);
      // won when no higher id is asserted on the bus
      arb_won <= (ids_s2 & ~((id_onehot(id_cfg.own_id) << 1) - 8'h01)) == 8'h00;
    end
  end

  sync_core_clock u_core_clock (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .scsi_clk_tick(scsi_clk_tick),
    .divide_code(clkdiv_reg[2:0]),
    .core_tick(core_tick)
  );

  assign computed_period = 4'(period_base + {1'b0, xfer_cfg.period_code}
    + {3'h0, clkdiv_reg[extra_setup_bit] && sending});
  assign sync_mode = (phase != phase_other) && (xfer_cfg.max_offset != 4'h0)
    && ({1'b0, xfer_cfg.max_offset} <= max_offset_limit);
  assign offset_ok = {1'b0, outstanding[3:0]} < {1'b0, xfer_cfg.max_offset};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_cnt <= 4'h0;
      data_strobe <= 1'b0;
      ack_prev <= 1'b0;
      outstanding <= 5'h00;
    end else if (clk_en) begin
      data_strobe <= 1'b0;
      ack_prev <= ack_sync[1];
      if (core_tick && gap_cnt != 4'h0) gap_cnt <= 4'(gap_cnt - 4'h1);
      if (sync_mode && sending && send_req && gap_cnt == 4'h0 && core_tick && offset_ok) begin
        data_strobe <= 1'b1;
        gap_cnt <= 4'(computed_period - 4'h1);
      end
      if (!sync_mode) outstanding <= 5'h00;
      else outstanding <= 5'(outstanding + {4'h0, data_strobe} - {4'h0, ack_sync[1] && !ack_prev});
    end
  end

  a_sel_gate: assert property (@(posedge clk) disable iff (!rst_n)
    sel_respond |-> $past(id_cfg.sel_en)) else $error("selection answered while disabled");
  a_resel_gate: assert property (@(posedge clk) disable iff (!rst_n)
    resel_respond |-> $past(id_cfg.resel_en)) else $error("reselection answered while disabled");
  a_role_kept: assert property (@(posedge clk) disable iff (!rst_n)
    role_target == role_target_in) else $error("role changed by bus event");
  a_arb_id: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && $stable(own_id_reg) |=> arb_id_drive == (8'h01 << $past(own_id_reg[2:0]))) else $error("wrong arbitration id");
  a_arb_top: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && own_id_reg[2:0] == 3'h7 |=> arb_won) else $error("id 7 lost arbitration");
  a_table_load: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && table_load |=> xfer_reg == ($past(table_xfer) & xfer_mask)) else $error("table load missed");
  a_script_dest: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && script_dest_we |=> dest_reg[2:0] == $past(script_dest_id)) else $error("script id not stored");
  a_async_other: assert property (@(posedge clk) disable iff (!rst_n)
    phase == phase_other |-> !sync_mode) else $error("sync outside data phase");
  a_offset_bound: assert property (@(posedge clk) disable iff (!rst_n)
    data_strobe |-> $past(offset_ok)) else $error("offset exceeded");
  a_strobe_gap: assert property (@(posedge clk) disable iff (!rst_n)
    data_strobe |=> !data_strobe [*3]) else $error("strobes closer than four cycles");
endmodule // scsi_id_sync_xfer_config
`default_nettype wire

// ==== src/sync_core_clock.sv ====
`default_nettype none
module sync_core_clock
  import scsi_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scsi_clk_tick,
  input wire logic [2:0] divide_code,
  output logic core_tick
);
  // accumulate two per scsi clock; fire when reaching the divisor in half clocks
  logic [2:0] acc;
  logic [2:0] limit;

  always_comb begin
    unique case (divide_code)
      div_code_1: limit = 3'h2;
      div_code_15: limit = 3'h3;
      div_code_2: limit = 3'h4;
      default: limit = 3'h6; // /3 for codes 0 and 4, reserved treated likewise
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc <= 3'h0;
      core_tick <= 1'b0;
    end else if (clk_en) begin
      core_tick <= 1'b0;
      if (scsi_clk_tick) begin
        if (3'(acc + 3'h2) >= limit) begin
          acc <= 3'(acc + 3'h2 - limit);
          core_tick <= 1'b1;
        end else begin
          acc <= 3'(acc + 3'h2);
        end
      end
    end
  end

  a_tick_cause: assert property (@(posedge clk) disable iff (!rst_n)
    core_tick |-> $past(scsi_clk_tick) && $past(clk_en)) else $error("core tick without scsi clock");
endmodule // sync_core_clock
`default_nettype wire
